// >>> src/fsq_seq.sv
// flash row/page program sequencer with avalon-mm register slave
`timescale 1ns/1ps
module fsq_seq #(
  parameter int ROW_CYC  = fsq_pkg::FSQ_ROW_CYC,   // row program duration
  parameter int PAGE_CYC = fsq_pkg::FSQ_PAGE_CYC   // page erase duration
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // avalon-mm slave
  input  wire logic [7:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  // processor stall and flash macro command
  output logic                        cpu_stall,
  output fsq_pkg::fsq_flash_cmd_t     flash_cmd
);
  import fsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  fsq_state_t            state_q;        // sequencer state
  logic [31:0]           rdata_q;        // read data register
  logic                  wait_q;         // waitrequest register
  logic                  stall_q;        // cpu stall register
  fsq_flash_cmd_t        cmd_q;          // flash command register
  logic                  start_q;        // start bit
  logic                  pgm_en_q;       // program enable
  logic                  err_q;          // sequence error
  logic                  erase_sel_q;    // erase select
  logic [FSQ_OP_W-1:0]   op_q;           // op select
  logic [7:0]            page_q;         // table page
  logic [15:0]           ea_q;           // effective address pointer
  logic                  key1_q;         // first key seen last write
  logic                  armed_q;        // full key seen last write
  logic [31:0]           tmr_q;          // operation timer
  logic [FSQ_IDX_W-1:0]  sidx_q;         // stream index
  logic [FSQ_PADR_W-1:0] target;         // joined program address
  logic [FSQ_INSTR_W-1:0] buf_rd;        // buffer read word
  logic                  req;            // access pending
  logic                  acc;            // access taken this edge
  logic                  wr_acc;         // write taken
  logic                  is_erase_op;    // decoded page erase
  logic                  is_row_op;      // decoded row program
  logic                  start_req;      // write of start bit
  logic                  go;             // start accepted
  logic [31:0]           ctrl_w;         // merged control write
  logic [31:0]           ctrl_rd;        // control read view
  logic [31:0]           page_w;         // merged table page write
  logic [31:0]           ea_w;           // merged pointer write

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign req       = read | write;
  assign acc       = req & ~wait_q;
  assign wr_acc    = write & ~wait_q;
  assign target    = {page_q, ea_q};
  assign ctrl_rd   = {16'h0000, start_q, pgm_en_q, err_q, 6'h00, erase_sel_q, 2'b00, op_q};
  assign ctrl_w    = be_merge(ctrl_rd, writedata, byteenable);
  assign page_w    = be_merge({24'h000000, page_q}, writedata, byteenable);
  assign ea_w      = be_merge({16'h0000, ea_q}, writedata, byteenable);
  assign start_req = wr_acc && (address == FSQ_ADR_CTRL) && ctrl_w[FSQ_BIT_START];
  assign is_erase_op = ctrl_w[FSQ_BIT_PGM_EN] && ctrl_w[FSQ_BIT_ERASE] &&
                       (ctrl_w[FSQ_OP_LSB +: FSQ_OP_W] == FSQ_OP_PAGE_ERASE);
  assign is_row_op   = ctrl_w[FSQ_BIT_PGM_EN] && !ctrl_w[FSQ_BIT_ERASE] &&
                       (ctrl_w[FSQ_OP_LSB +: FSQ_OP_W] == FSQ_OP_ROW_PROG);
  assign go        = start_req && armed_q && (is_erase_op || is_row_op);

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, held while an operation runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q && (state_q == FSQ_IDLE));
    end
  end

  // read data captured as waitrequest drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && wait_q && (state_q == FSQ_IDLE)) begin
      if (address == FSQ_ADR_CTRL) begin
        rdata_q <= ctrl_rd;
      end else if (address == FSQ_ADR_PAGE) begin
        rdata_q <= {24'h000000, page_q};
      end else if (address == FSQ_ADR_EA) begin
        rdata_q <= {16'h0000, ea_q};
      end else begin  // key, table ports, unmapped read zero
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pgm_en_q    <= 1'b0;
      erase_sel_q <= 1'b0;
      op_q        <= '0;
    end else if (wr_acc && (address == FSQ_ADR_CTRL)) begin
      pgm_en_q    <= ctrl_w[FSQ_BIT_PGM_EN];
      erase_sel_q <= ctrl_w[FSQ_BIT_ERASE];
      op_q        <= ctrl_w[FSQ_OP_LSB +: FSQ_OP_W];
    end
  end

  // error flag: hardware set beats software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if (start_req && !go) begin
      err_q <= 1'b1;
    end else if (wr_acc && (address == FSQ_ADR_CTRL)) begin
      err_q <= ctrl_w[FSQ_BIT_ERR];
    end
  end

  // start bit: set by accepted start, cleared at completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else if (go) begin
      start_q <= 1'b1;
    end else if ((state_q == FSQ_WAIT) && (tmr_q == 32'h0000_0000)) begin
      start_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unlock tracking: any write other than the next key drops it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key1_q  <= 1'b0;
      armed_q <= 1'b0;
    end else if (wr_acc) begin
      key1_q  <= (address == FSQ_ADR_KEY) && byteenable[0] && (writedata[7:0] == FSQ_KEY_FIRST);
      armed_q <= (address == FSQ_ADR_KEY) && byteenable[0] && key1_q &&
                 (writedata[7:0] == FSQ_KEY_SECOND);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // table page and pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_q <= 8'h00;
      ea_q   <= 16'h0000;
    end else if (wr_acc) begin
      if (address == FSQ_ADR_PAGE) begin
        page_q <= page_w[7:0];
      end else if (address == FSQ_ADR_EA) begin
        ea_q <= ea_w[15:0];
      end else if (address == FSQ_ADR_TWH) begin
        ea_q <= ea_q + FSQ_EA_STEP;
      end
    end
  end

  // holding buffer
  fsq_hold_buf u_buf (
    .clk      (clk),
    .rst      (rst),
    .we_lo    (wr_acc && (address == FSQ_ADR_TWL)),
    .we_hi    (wr_acc && (address == FSQ_ADR_TWH)),
    .widx     (ea_q[FSQ_IDX_W:1]),
    .wdata_lo (writedata[15:0]),
    .wdata_hi (writedata[7:0]),
    .ridx     (sidx_q),
    .rdata    (buf_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= FSQ_IDLE;
      tmr_q   <= 32'h0000_0000;
      sidx_q  <= '0;
      cmd_q   <= '0;
    end else begin
      cmd_q.erase <= 1'b0;
      cmd_q.prog  <= 1'b0;
      case (state_q)
        FSQ_IDLE: begin
          if (go && is_erase_op) begin
            state_q <= FSQ_ERASE;
            cmd_q.addr <= {target[FSQ_PADR_W-1:FSQ_PAGE_ALIGN], FSQ_PAGE_ALIGN'(0)};
          end else if (go) begin
            state_q <= FSQ_STREAM;
            sidx_q  <= '0;
            cmd_q.addr <= {target[FSQ_PADR_W-1:FSQ_ROW_ALIGN], FSQ_ROW_ALIGN'(0)};
          end
        end
        FSQ_ERASE: begin  // one erase pulse on the aligned page
          cmd_q.erase <= 1'b1;
          tmr_q   <= 32'(PAGE_CYC - 1);
          state_q <= FSQ_WAIT;
        end
        FSQ_STREAM: begin  // one word per cycle from the buffer
          cmd_q.prog <= 1'b1;
          cmd_q.data <= buf_rd;
          if (sidx_q != FSQ_IDX_W'(0) || cmd_q.prog) begin
            cmd_q.addr <= cmd_q.addr + FSQ_ADR_STEP;
          end
          sidx_q <= sidx_q + FSQ_IDX_W'(1);
          if (sidx_q == FSQ_IDX_W'(FSQ_ROW_WORDS - 1)) begin
            tmr_q   <= 32'(ROW_CYC - 1);
            state_q <= FSQ_WAIT;
          end
        end
        FSQ_WAIT: begin  // self-timed program/erase
          if (tmr_q == 32'h0000_0000) begin
            state_q <= FSQ_IDLE;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        default: begin
          state_q <= FSQ_IDLE;
        end
      endcase
    end
  end

  // processor stall follows the busy sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= go || ((state_q != FSQ_IDLE) &&
                 !((state_q == FSQ_WAIT) && (tmr_q == 32'h0000_0000)));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign readdata    = rdata_q;
  assign waitrequest = wait_q;
  assign cpu_stall   = stall_q;
  assign flash_cmd   = cmd_q;
endmodule : fsq_seq

// >>> src/fsq_pkg.sv
// shared constants and types of the flash row/page program sequencer
package fsq_pkg;
  // register byte addresses on the avalon slave
  localparam logic [7:0]  FSQ_ADR_CTRL      = 8'h00;     // flash_control_reg
  localparam logic [7:0]  FSQ_ADR_KEY       = 8'h04;     // unlock_key_reg
  localparam logic [7:0]  FSQ_ADR_PAGE      = 8'h08;     // table_page_reg
  localparam logic [7:0]  FSQ_ADR_EA        = 8'h0C;     // effective address pointer
  localparam logic [7:0]  FSQ_ADR_TWL       = 8'h10;     // table_write_low port
  localparam logic [7:0]  FSQ_ADR_TWH       = 8'h14;     // table_write_high port
  // control register fields
  localparam int          FSQ_BIT_START     = 15;        // start / busy bit
  localparam int          FSQ_BIT_PGM_EN    = 14;        // program_enable_bit
  localparam int          FSQ_BIT_ERR       = 13;        // sequence error flag
  localparam int          FSQ_BIT_ERASE     = 6;         // erase select
  localparam int          FSQ_OP_LSB        = 0;         // op_select_field lsb
  localparam int          FSQ_OP_W          = 4;         // op_select_field width
  localparam logic [3:0]  FSQ_OP_PAGE_ERASE = 4'h2;      // with erase set
  localparam logic [3:0]  FSQ_OP_ROW_PROG   = 4'h1;      // with erase clear
  // unlock keys
  localparam logic [7:0]  FSQ_KEY_FIRST     = 8'h55;
  localparam logic [7:0]  FSQ_KEY_SECOND    = 8'hAA;
  // geometry
  localparam int          FSQ_ROW_WORDS     = 64;        // instructions per row
  localparam int          FSQ_IDX_W         = 6;         // log2 of row words
  localparam int          FSQ_PADR_W        = 24;        // program address width
  localparam int          FSQ_INSTR_W       = 24;        // instruction width
  localparam int          FSQ_PAGE_ALIGN    = 10;        // 512 instr x 2 addr units
  localparam int          FSQ_ROW_ALIGN     = 7;         // 64 instr x 2 addr units
  localparam logic [15:0] FSQ_EA_STEP       = 16'h0002;  // post-increment per instr
  localparam logic [23:0] FSQ_ADR_STEP      = 24'h000002;
  // timing
  localparam int          FSQ_CLK_NS        = 4;         // 250 MHz
  localparam int          FSQ_T_ROW_US      = 1480;      // least row write time
  localparam int          FSQ_T_PAGE_US     = 20000;     // page erase time, plain default
  localparam int          FSQ_ROW_CYC       = (FSQ_T_ROW_US * 1000 + FSQ_CLK_NS - 1) / FSQ_CLK_NS;
  localparam int          FSQ_PAGE_CYC      = (FSQ_T_PAGE_US * 1000 + FSQ_CLK_NS - 1) / FSQ_CLK_NS;
  localparam logic [23:0] FSQ_ERASED        = 24'hFFFFFF;
  // sequencer states
  typedef enum logic [3:0] {
    FSQ_IDLE   = 4'b0001,
    FSQ_ERASE  = 4'b0010,
    FSQ_STREAM = 4'b0100,
    FSQ_WAIT   = 4'b1000
  } fsq_state_t;
  // command to the flash array macro
  typedef struct packed {
    logic        erase;   // page erase pulse
    logic        prog;    // one word program pulse
    logic [23:0] addr;    // target program address
    logic [23:0] data;    // word to program
  } fsq_flash_cmd_t;
endpackage : fsq_pkg

// >>> src/fsq_hold_buf.sv
// 64-instruction holding buffer loaded by table writes
`timescale 1ns/1ps
module fsq_hold_buf (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // load side
  input  wire logic                         we_lo,
  input  wire logic                         we_hi,
  input  wire logic [fsq_pkg::FSQ_IDX_W-1:0] widx,
  input  wire logic [15:0]                  wdata_lo,
  input  wire logic [7:0]                   wdata_hi,
  // drain side
  input  wire logic [fsq_pkg::FSQ_IDX_W-1:0] ridx,
  output logic      [fsq_pkg::FSQ_INSTR_W-1:0] rdata
);
  import fsq_pkg::*;

  logic [FSQ_INSTR_W-1:0] mem_q [FSQ_ROW_WORDS];  // buffer entries

  ////////////////////////////////////////////////////////////////////////
  // one flop group per entry; entries not loaded since reset read as erased
  genvar g;
  generate
    for (g = 0; g < FSQ_ROW_WORDS; g++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_q[g] <= FSQ_ERASED;
        end else if (widx == FSQ_IDX_W'(g)) begin
          if (we_lo) begin  // low word lane
            mem_q[g][15:0] <= wdata_lo;
          end
          if (we_hi) begin  // high byte lane
            mem_q[g][23:16] <= wdata_hi;
          end
        end
      end
    end
  endgenerate

  // indexed read for the program stream
  assign rdata = mem_q[ridx];
endmodule : fsq_hold_buf

// >>> sim/fsq_seq_assertions.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/1ps
module fsq_seq_chk #(
  parameter int ROW_CYC  = 20,  // row program duration
  parameter int PAGE_CYC = 30   // page erase duration
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // bus and outputs
  input wire logic [7:0]              address,
  input wire logic                    write,
  input wire logic [31:0]             writedata,
  input wire logic                    waitrequest,
  input wire logic                    cpu_stall,
  input wire fsq_pkg::fsq_flash_cmd_t flash_cmd
);
  import fsq_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [6:0] cnt_q;  // length of the running program burst
  logic [31:0] stl_q; // length of the running stall
  ////////////////////////////////////////////////////////////////
  // burst length counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_q <= 7'h00;
    else cnt_q <= flash_cmd.prog ? cnt_q + 7'h01 : 7'h00;
  end
  // stall length counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) stl_q <= 32'h0000_0000;
    else stl_q <= cpu_stall ? stl_q + 32'h0000_0001 : 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_burst8;
    flash_cmd.prog [*8];
  endsequence
  sequence s_pulse_end;
    cpu_stall ##1 !flash_cmd.erase;
  endsequence
  property p_wait_one; !waitrequest |=> waitrequest; endproperty
  property p_stall_bus; cpu_stall |-> waitrequest; endproperty
  property p_stall_start;
    $rose(cpu_stall) |-> $past(write && !waitrequest && address == FSQ_ADR_CTRL && writedata[FSQ_BIT_START]);
  endproperty
  property p_erase_pulse; flash_cmd.erase |-> s_pulse_end; endproperty
  property p_erase_align; flash_cmd.erase |-> flash_cmd.addr[9:0] == 10'h000; endproperty
  property p_row_align; $rose(flash_cmd.prog) |-> flash_cmd.addr[6:0] == 7'h00 && cpu_stall; endproperty
  property p_prog_step;
    flash_cmd.prog && $past(flash_cmd.prog) |-> flash_cmd.addr == $past(flash_cmd.addr) + FSQ_ADR_STEP;
  endproperty
  property p_burst; $rose(flash_cmd.prog) |-> s_burst8; endproperty
  property p_burst_len; $fell(flash_cmd.prog) |-> cnt_q == 7'h40; endproperty
  property p_stall_len;
    $fell(cpu_stall) |-> stl_q == 32'(PAGE_CYC + 1) || stl_q == 32'(ROW_CYC + 64);
  endproperty
  a_wait_one:    assert property (p_wait_one) else $error("wait low longer than one cycle");
  a_stall_bus:   assert property (p_stall_bus) else $error("bus answered during operation");
  a_stall_start: assert property (p_stall_start) else $error("stall without start write");
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse malformed");
  a_erase_align: assert property (p_erase_align) else $error("erase address unaligned");
  a_row_align:   assert property (p_row_align) else $error("row address unaligned");
  a_prog_step:   assert property (p_prog_step) else $error("program address step wrong");
  a_burst:       assert property (p_burst) else $error("program burst broken");
  a_burst_len:   assert property (p_burst_len) else $error("program burst not 64 words");
  a_stall_len:   assert property (p_stall_len) else $error("operation length wrong");
endmodule : fsq_seq_chk
bind fsq_seq fsq_seq_chk #(.ROW_CYC(ROW_CYC), .PAGE_CYC(PAGE_CYC)) u_chk (.clk(clk), .rst(rst),
  .address(address), .write(write), .writedata(writedata), .waitrequest(waitrequest),
  .cpu_stall(cpu_stall), .flash_cmd(flash_cmd));

// >>> sim/fsq_cpu_model.sv
// processor core model issuing register and table writes
`timescale 1ns/1ps
module fsq_cpu_model (
  // clock
  input  wire logic        clk,
  // avalon-mm master side
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic      [7:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  import fsq_pkg::*;
  // idle bus at time zero
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
  end
  // one access, held until waitrequest is sampled low
  task automatic access(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr_en;
    read <= !wr_en;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    address <= ~a;    // released lines no longer hold the value
    writedata <= ~d;
  endtask : access
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask : wr
  // two keys back to back, no other write between
  task automatic unlock();
    wr(FSQ_ADR_KEY, 32'h00000055);
    wr(FSQ_ADR_KEY, 32'h000000AA);
  endtask : unlock
endmodule : fsq_cpu_model

// >>> sim/fsq_seq_tb.sv
// self-checking bench for the flash program sequencer
`timescale 1ns/1ps
module fsq_seq_tb;
  import fsq_pkg::*;
  logic           clk = 1'b0;     // 250 MHz
  logic           rst = 1'b1;     // async, active high
  logic [7:0]     address;
  logic           read;
  logic           write;
  logic [31:0]    writedata;
  logic [3:0]     byteenable;
  logic [31:0]    readdata;
  logic           waitrequest;
  logic           cpu_stall;
  fsq_flash_cmd_t flash_cmd;
  int             n_errors = 0;
  int             comparisons = 0;
  int             cyc = 0;        // timeout counter
  int             er_n = 0;       // erase pulses seen
  int             pn = 0;         // program pulses seen
  logic [23:0]    er_a, w;
  logic [23:0]    pa [64];
  logic [23:0]    pd [64];
  logic [31:0]    q;
  logic [71:0]    rows [4];       // address, write data, read back
  logic [15:0]    bad [3];        // refused control words
  always #2 clk = ~clk;
  fsq_seq #(.ROW_CYC(20), .PAGE_CYC(30)) DUT (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cpu_stall(cpu_stall), .flash_cmd(flash_cmd));
  fsq_cpu_model cpu (.clk(clk), .readdata(readdata), .waitrequest(waitrequest), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));
  ////////////////////////////////////////////////////////////////
  // flash command monitor and timeout
  always @(posedge clk) begin
    cyc++;
    if (flash_cmd.erase === 1'b1) begin er_n++; er_a = flash_cmd.addr; end
    if (flash_cmd.prog === 1'b1) begin
      pa[pn % 64] = flash_cmd.addr;
      pd[pn % 64] = flash_cmd.data;
      pn++;
    end
    if (cyc == 20000) begin n_errors++; finish_test(); end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin n_errors++; $display("MISMATCH %s exp=%h seen=%h", nm, e, s); end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    cpu.access(1'b0, a, 32'h00000000, q);
    chk(nm, q, e);
  endtask : rchk
  // start write, stall seen, wait for the end
  task automatic run(input logic [31:0] c);
    cpu.wr(FSQ_ADR_CTRL, c);
    repeat (2) @(posedge clk);
    chk("stall", {31'h0, cpu_stall}, 32'h1);
    while (cpu_stall !== 1'b0) @(posedge clk);
  endtask : run
  function automatic logic [23:0] wd(input int i);
    return {8'(i) ^ 8'h5A, 8'hC3, 8'(i)};
  endfunction : wd
  task automatic finish_test();
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = {FSQ_ADR_PAGE, 32'h000001FF, 32'h000000FF};
    rows[1] = {FSQ_ADR_EA, 32'h00012345, 32'h00002345};
    rows[2] = {FSQ_ADR_KEY, 32'h00000055, 32'h00000000};
    rows[3] = {8'h18, 32'h0000FFFF, 32'h00000000};
    bad = '{16'hC003, 16'hC041, 16'h8042};
    repeat (10) @(posedge clk);
    chk("stall_rst", {31'h0, cpu_stall}, 32'h0);
    rst <= 1'b0;
    rchk(FSQ_ADR_CTRL, 32'h0, "ctrl_rst");
    for (int i = 0; i < 4; i++) begin
      cpu.wr(rows[i][71:64], rows[i][63:32]);
      rchk(rows[i][71:64], rows[i][31:0], "reg");
    end
    // start with no keys, then keys broken by a write
    cpu.wr(FSQ_ADR_CTRL, 32'h0000C042);
    rchk(FSQ_ADR_CTRL, 32'h00006042, "nokey");
    cpu.wr(FSQ_ADR_KEY, 32'h55);
    cpu.wr(FSQ_ADR_PAGE, 32'h01);
    cpu.wr(FSQ_ADR_KEY, 32'hAA);
    cpu.wr(FSQ_ADR_CTRL, 32'h0000C042);
    rchk(FSQ_ADR_CTRL, 32'h00006042, "split");
    // page erase
    cpu.wr(FSQ_ADR_CTRL, 32'h00004042);
    cpu.wr(FSQ_ADR_EA, 32'h00000C34);
    cpu.unlock();
    run(32'h0000C042);
    rchk(FSQ_ADR_CTRL, 32'h00004042, "erase_done");
    chk("er_n", er_n, 1);
    chk("er_a", {8'h0, er_a}, 32'h00010C00);
    // second start reuses a spent unlock
    cpu.wr(FSQ_ADR_CTRL, 32'h0000C042);
    rchk(FSQ_ADR_CTRL, 32'h00006042, "reuse");
    // load 64 words per row and program two rows of the erased page
    for (int r = 0; r < 2; r++) begin
      cpu.wr(FSQ_ADR_CTRL, 32'h00004001);
      cpu.wr(FSQ_ADR_EA, 32'h00000C80 + 32'(r * 128));
      for (int i = 0; i < 64; i++) begin
        w = wd(r * 64 + i);
        cpu.wr(FSQ_ADR_TWL, {16'h0, w[15:0]});
        cpu.wr(FSQ_ADR_TWH, {24'h0, w[23:16]});
      end
      rchk(FSQ_ADR_EA, 32'h00000D00 + 32'(r * 128), "ea_inc");
      cpu.wr(FSQ_ADR_EA, 32'h00000C80 + 32'(r * 128));
      cpu.unlock();
      run(32'h0000C001);
      rchk(FSQ_ADR_CTRL, 32'h00004001, "row_done");
      chk("pn", pn, 64 * (r + 1));
      for (int i = 0; i < 64; i++) begin
        chk("paddr", {8'h0, pa[i]}, 32'h00010C80 + 32'(r * 128 + i * 2));
        chk("pdata", {8'h0, pd[i]}, {8'h0, wd(r * 64 + i)});
      end
    end
    // unlocked but unsupported settings are refused
    for (int i = 0; i < 3; i++) begin
      cpu.unlock();
      cpu.wr(FSQ_ADR_CTRL, {16'h0, bad[i]});
      rchk(FSQ_ADR_CTRL, {16'h0, bad[i] & 16'h7FFF | 16'h2000}, "bad_op");
    end
    chk("no_ops", er_n + pn, 129);
    // reset in mid-operation returns to idle values
    cpu.unlock();
    cpu.wr(FSQ_ADR_CTRL, 32'h0000C042);
    repeat (3) @(posedge clk);
    chk("er_mid", er_n, 2);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("stall_mid", {31'h0, cpu_stall}, 32'h0);
    rst <= 1'b0;
    rchk(FSQ_ADR_CTRL, 32'h0, "ctrl_mid");
    rchk(FSQ_ADR_EA, 32'h0, "ea_mid");
    finish_test();
  end
endmodule : fsq_seq_tb
